// [common/spllc_consts.svh]
`ifndef SPLLC_CONSTS_SVH
`define SPLLC_CONSTS_SVH

// Register offsets
`define SPLLC_ADDR_INPUT_DOUBLER_PREDIVIDER 8'h20
`define SPLLC_ADDR_FEEDBACK_PREDIV_SOURCE_MODE 8'h21
`define SPLLC_ADDR_PUMP_POWER_GAIN_CONTROL 8'h28
`define SPLLC_ADDR_PUMP_OFFSET_CURRENT 8'h29

// Reset values
`define SPLLC_RST_INPUT_DOUBLER_PREDIVIDER 8'h01
`define SPLLC_RST_FEEDBACK_PREDIV_SOURCE_MODE 8'h90
`define SPLLC_RST_PUMP_POWER_GAIN_CONTROL 8'h30
`define SPLLC_RST_PUMP_OFFSET_CURRENT 8'h00
`define SPLLC_RST_INPUT_DIVIDE 7'h01
`define SPLLC_RST_SOURCE_INVALID 1'h0
`define SPLLC_RST_PUMP_CURRENT 5'h10
`define SPLLC_RST_PUMP_OFFSET_SUM 6'h00

// Writable bit masks, reserved bits clear
`define SPLLC_MASK_INPUT_DOUBLER_PREDIVIDER 8'hFF
`define SPLLC_MASK_FEEDBACK_PREDIV_SOURCE_MODE 8'hF8
`define SPLLC_MASK_PUMP_POWER_GAIN_CONTROL 8'hBF
`define SPLLC_MASK_PUMP_OFFSET_CURRENT 8'h3F

// Field positions
`define SPLLC_BIT_DOUBLER 7
`define SPLLC_BIT_VCXO_HALVE 7
`define SPLLC_BIT_EXT_HALVE 6
`define SPLLC_POS_SOURCE 4
`define SPLLC_BIT_BYPASS 3
`define SPLLC_BIT_PUMP_PD 7
`define SPLLC_BIT_SINK_EN 5
`define SPLLC_BIT_STEP_X2 4

// Pump current figures, in 100 uA units
`define SPLLC_PUMP_BASE_X2 5'h10

`endif

// [common/spllc_pkg.sv]
package spllc_pkg;

	typedef enum logic [1:0] {
		SPLLC_SRC_EXT_OSC = 2'b00,
		SPLLC_SRC_SECOND_PLL = 2'b01,
		SPLLC_SRC_FIRST_PLL = 2'b10,
		SPLLC_SRC_REFERENCE = 2'b11
	} spllc_source_e;

	typedef struct packed {
		logic [7:0] doubler_prediv_r;
		logic [7:0] fb_src_mode_r;
		logic [7:0] pump_gain_r;
		logic [7:0] pump_offset_r;
		logic [7:0] rdata_r;
		logic [6:0] input_divide_r;
		logic source_invalid_r;
		logic [4:0] pump_current_r;
		logic [5:0] pump_offset_sum_r;
	} spllc_state_s;

endpackage

// [hw/spllc_regs.sv]
`timescale 1ns/1ns
`default_nettype none
`include "spllc_consts.svh"

// How it works
// - Doubler bit at 1 feeds the second PLL with the doubled bypass-mux output and ignores the pre-divider, at 0 the pre-divided signal.
// - The pre-divider is a 7-bit binary ratio from 1 to 127, resetting to 1 which means bypassed.
// - The VCXO halve bit resets to 1 and then doubles the total first-PLL feedback ratio, at 0 the divider alone is used.
// - The external oscillator halve bit resets to 0 (undivided) and at 1 halves the external oscillator.
// - The output source field resets to 01 and picks external osc, second PLL, first PLL or reference, code 11 only valid in bypass mode.
// - The mode bit resets to 0 for dual-PLL mode and at 1 selects synthesizer mode with the first PLL bypassed.
// - The pump power-down bit resets to 0 (powered) and at 1 powers the pump down.
// - The sink enable bit resets to 1 with sink equal to source, and at 0 disables sink current.
// - The multiplier bit resets to 1, giving 200 uA gain steps, and 100 uA steps at 0.
// - With the multiplier at 0 the gain code weighs 800, 400, 200 and 100 uA from bit 3 down.
// - With the multiplier at 1 the current is 1600 uA plus 800, 400, 200 uA for bits 2 to 0, reset giving 1.6 mA.
// - The 6-bit offset code resets to zero and adds 200, 100, 100, 50, 25, 12.5 uA from bit 5 down.
module spllc_regs
	import spllc_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic INPUT_DOUBLER_SELECT,
	output logic [6:0] SECOND_PLL_PREDIVIDER,
	output logic [6:0] SECOND_PLL_INPUT_DIVIDE,
	output logic VCXO_FEEDBACK_HALVE_SELECT,
	output logic EXTERNAL_OSC_HALVE_SELECT,
	output logic [1:0] OUTPUT_SOURCE_SELECT,
	output logic SOURCE_SELECT_INVALID,
	output logic FIRST_PLL_BYPASS_MODE,
	output logic PUMP_POWER_DOWN,
	output logic PUMP_ENABLE,
	output logic PUMP_SINK_ENABLE,
	output logic PUMP_STEP_MULTIPLIER,
	output logic [3:0] PUMP_GAIN_CODE,
	output logic [4:0] PUMP_CURRENT_100UA,
	output logic [5:0] PUMP_OFFSET_CODE,
	output logic [5:0] PUMP_OFFSET_12P5UA
);

	////////////////////////////////////////////////////////////////////////////////
	// Decoders

	localparam logic [3:0] HIT_DOUBLER = 4'h1;
	localparam logic [3:0] HIT_SOURCE = 4'h2;
	localparam logic [3:0] HIT_GAIN = 4'h4;
	localparam logic [3:0] HIT_OFFSET = 4'h8;
	localparam logic [5:0] OFFSET_WEIGHT [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h08, 6'h10};
	localparam logic [4:0] GAIN_WEIGHT [4] = '{5'h01, 5'h02, 5'h04, 5'h08};

	function automatic logic [3:0] addr_hit(input logic [7:0] addr);
		case (addr)
			`SPLLC_ADDR_INPUT_DOUBLER_PREDIVIDER: begin
				addr_hit = HIT_DOUBLER;
			end
			`SPLLC_ADDR_FEEDBACK_PREDIV_SOURCE_MODE: begin
				addr_hit = HIT_SOURCE;
			end
			`SPLLC_ADDR_PUMP_POWER_GAIN_CONTROL: begin
				addr_hit = HIT_GAIN;
			end
			`SPLLC_ADDR_PUMP_OFFSET_CURRENT: begin
				addr_hit = HIT_OFFSET;
			end
			default: begin
				addr_hit = 4'h0;
			end
		endcase
	endfunction

	function automatic logic [7:0] masked_write(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask);
		masked_write = (new_v & mask) | (old_v & ~mask);
	endfunction

	function automatic logic [4:0] pump_current(input logic x2, input logic [3:0] gain);
		logic [4:0] sum;
		sum = x2 ? `SPLLC_PUMP_BASE_X2 : 5'h00;
		for (int i = 0; i < 3; i++) begin
			if (gain[i]) begin
				sum = sum + (x2 ? GAIN_WEIGHT[i + 1] : GAIN_WEIGHT[i]);
			end
		end
		if (gain[3] && !x2) begin
			sum = sum + GAIN_WEIGHT[3];
		end
		pump_current = sum;
	endfunction

	function automatic logic [5:0] offset_current(input logic [5:0] code);
		logic [5:0] sum;
		sum = 6'h00;
		for (int i = 0; i < 6; i++) begin
			if (code[i]) begin
				sum = sum + OFFSET_WEIGHT[i];
			end
		end
		offset_current = sum;
	endfunction

	function automatic logic [6:0] input_divide(input logic [7:0] value);
		if (value[`SPLLC_BIT_DOUBLER]) begin
			input_divide = 7'h01;
		end else begin
			input_divide = value[6:0];
		end
	endfunction

	function automatic logic source_invalid(input logic [7:0] value);
		source_invalid = (value[`SPLLC_POS_SOURCE +: 2] == SPLLC_SRC_REFERENCE)
			&& !value[`SPLLC_BIT_BYPASS];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State

	spllc_state_s st_r;
	spllc_state_s st_nxt;
	logic [3:0] wr_hit;
	logic [3:0] rd_hit;

	assign wr_hit = REG_WR ? addr_hit(REG_ADDR) : 4'h0;
	assign rd_hit = REG_RD ? addr_hit(REG_ADDR) : 4'h0;

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata_r = 8'h00;
		if (REG_WR) begin
			case (wr_hit)
				HIT_DOUBLER: begin
					st_nxt.doubler_prediv_r = masked_write(st_r.doubler_prediv_r, REG_WDATA,
						`SPLLC_MASK_INPUT_DOUBLER_PREDIVIDER);
				end
				HIT_SOURCE: begin
					st_nxt.fb_src_mode_r = masked_write(st_r.fb_src_mode_r, REG_WDATA,
						`SPLLC_MASK_FEEDBACK_PREDIV_SOURCE_MODE);
				end
				HIT_GAIN: begin
					st_nxt.pump_gain_r = masked_write(st_r.pump_gain_r, REG_WDATA,
						`SPLLC_MASK_PUMP_POWER_GAIN_CONTROL);
				end
				HIT_OFFSET: begin
					st_nxt.pump_offset_r = masked_write(st_r.pump_offset_r, REG_WDATA,
						`SPLLC_MASK_PUMP_OFFSET_CURRENT);
				end
				default: begin
				end
			endcase
		end
		if (REG_RD) begin
			case (rd_hit)
				HIT_DOUBLER: begin
					st_nxt.rdata_r = st_r.doubler_prediv_r;
				end
				HIT_SOURCE: begin
					st_nxt.rdata_r = st_r.fb_src_mode_r;
				end
				HIT_GAIN: begin
					st_nxt.rdata_r = st_r.pump_gain_r;
				end
				HIT_OFFSET: begin
					st_nxt.rdata_r = st_r.pump_offset_r;
				end
				default: begin
					st_nxt.rdata_r = 8'h00;
				end
			endcase
		end

		// Derived outputs, registered with their fields
		st_nxt.input_divide_r = input_divide(st_nxt.doubler_prediv_r);
		st_nxt.source_invalid_r = source_invalid(st_nxt.fb_src_mode_r);
		st_nxt.pump_current_r = pump_current(st_nxt.pump_gain_r[`SPLLC_BIT_STEP_X2],
			st_nxt.pump_gain_r[3:0]);
		st_nxt.pump_offset_sum_r = offset_current(st_nxt.pump_offset_r[5:0]);
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			st_r.doubler_prediv_r <= `SPLLC_RST_INPUT_DOUBLER_PREDIVIDER;
			st_r.fb_src_mode_r <= `SPLLC_RST_FEEDBACK_PREDIV_SOURCE_MODE;
			st_r.pump_gain_r <= `SPLLC_RST_PUMP_POWER_GAIN_CONTROL;
			st_r.pump_offset_r <= `SPLLC_RST_PUMP_OFFSET_CURRENT;
			st_r.rdata_r <= 8'h00;
			st_r.input_divide_r <= `SPLLC_RST_INPUT_DIVIDE;
			st_r.source_invalid_r <= `SPLLC_RST_SOURCE_INVALID;
			st_r.pump_current_r <= `SPLLC_RST_PUMP_CURRENT;
			st_r.pump_offset_sum_r <= `SPLLC_RST_PUMP_OFFSET_SUM;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign REG_RDATA = st_r.rdata_r;
	assign INPUT_DOUBLER_SELECT = st_r.doubler_prediv_r[`SPLLC_BIT_DOUBLER];
	assign SECOND_PLL_PREDIVIDER = st_r.doubler_prediv_r[6:0];
	assign SECOND_PLL_INPUT_DIVIDE = st_r.input_divide_r;
	assign VCXO_FEEDBACK_HALVE_SELECT = st_r.fb_src_mode_r[`SPLLC_BIT_VCXO_HALVE];
	assign EXTERNAL_OSC_HALVE_SELECT = st_r.fb_src_mode_r[`SPLLC_BIT_EXT_HALVE];
	assign OUTPUT_SOURCE_SELECT = st_r.fb_src_mode_r[`SPLLC_POS_SOURCE +: 2];
	assign FIRST_PLL_BYPASS_MODE = st_r.fb_src_mode_r[`SPLLC_BIT_BYPASS];
	assign SOURCE_SELECT_INVALID = st_r.source_invalid_r;
	assign PUMP_POWER_DOWN = st_r.pump_gain_r[`SPLLC_BIT_PUMP_PD];
	assign PUMP_ENABLE = !PUMP_POWER_DOWN;
	assign PUMP_SINK_ENABLE = st_r.pump_gain_r[`SPLLC_BIT_SINK_EN];
	assign PUMP_STEP_MULTIPLIER = st_r.pump_gain_r[`SPLLC_BIT_STEP_X2];
	assign PUMP_GAIN_CODE = st_r.pump_gain_r[3:0];
	assign PUMP_CURRENT_100UA = st_r.pump_current_r;
	assign PUMP_OFFSET_CODE = st_r.pump_offset_r[5:0];
	assign PUMP_OFFSET_12P5UA = st_r.pump_offset_sum_r;

endmodule // spllc_regs
`default_nettype wire

// [tb/spllc_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module spllc_chk (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic PUMP_POWER_DOWN,
	input wire logic PUMP_ENABLE,
	input wire logic PUMP_STEP_MULTIPLIER,
	input wire logic [3:0] PUMP_GAIN_CODE,
	input wire logic [4:0] PUMP_CURRENT_100UA,
	input wire logic [5:0] PUMP_OFFSET_CODE,
	input wire logic [5:0] PUMP_OFFSET_12P5UA
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	a_pump_enable: assert property (PUMP_ENABLE != PUMP_POWER_DOWN) else $error("enable");
	a_step_single: assert property (!PUMP_STEP_MULTIPLIER |->
		PUMP_CURRENT_100UA == {1'h0, PUMP_GAIN_CODE}) else $error("x1 current");
	a_step_double: assert property (PUMP_STEP_MULTIPLIER |->
		PUMP_CURRENT_100UA == 5'h10 + {1'h0, PUMP_GAIN_CODE[2:0], 1'h0}) else $error("x2 current");
	a_offset_sum: assert property (PUMP_OFFSET_12P5UA ==
		{1'h0, PUMP_OFFSET_CODE[5:4], 3'h0} + {2'h0, PUMP_OFFSET_CODE[3:0]}) else $error("offset");
	a_read_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00) else $error("rdata idle");
	a_hold_config: assert property (!REG_WR |=>
		$stable(PUMP_GAIN_CODE) && $stable(PUMP_OFFSET_CODE)) else $error("config moved");
	a_reset_pump: assert property (disable iff (1'h0) !RESET_N |=>
		PUMP_STEP_MULTIPLIER && PUMP_GAIN_CODE == 4'h0 && !PUMP_POWER_DOWN) else $error("reset");
	a_reset_clear: assert property (disable iff (1'h0) !RESET_N |=>
		REG_RDATA == 8'h00 && PUMP_OFFSET_CODE == 6'h00) else $error("reset clear");
endmodule // spllc_chk
bind spllc_regs spllc_chk u_spllc_chk (.*);
`default_nettype wire

// [tb/spllc_regs_test.sv]
`timescale 1ns/1ns
`default_nettype none
module spllc_regs_test;
	logic MCLK = 1'h0, RESET_N = 1'h0, REG_WR = 1'h0, REG_RD = 1'h0;
	logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, m [4];
	logic [7:0] ad [5] = '{8'h20, 8'h21, 8'h28, 8'h29, 8'h22}, cv [4] = '{8'hFF, 8'h00, 8'h30, 8'h38};
	logic [7:0] rs [4] = '{8'h01, 8'h90, 8'h30, 8'h00}, mk [4] = '{8'hFF, 8'hF8, 8'hBF, 8'h3F};
	wire logic [53:0] got;
	int failures = 0, compares = 0, seed = 32'h8BBC;
	spllc_regs u_spllc_regs (.*, .REG_RDATA(got[53:46]), .INPUT_DOUBLER_SELECT(got[45]),
		.SECOND_PLL_PREDIVIDER(got[44:38]), .SECOND_PLL_INPUT_DIVIDE(got[37:31]),
		.VCXO_FEEDBACK_HALVE_SELECT(got[30]), .EXTERNAL_OSC_HALVE_SELECT(got[29]),
		.OUTPUT_SOURCE_SELECT(got[28:27]), .SOURCE_SELECT_INVALID(got[26]), .PUMP_ENABLE(got[23]),
		.FIRST_PLL_BYPASS_MODE(got[25]), .PUMP_POWER_DOWN(got[24]), .PUMP_SINK_ENABLE(got[22]),
		.PUMP_STEP_MULTIPLIER(got[21]), .PUMP_GAIN_CODE(got[20:17]), .PUMP_CURRENT_100UA(got[16:12]),
		.PUMP_OFFSET_CODE(got[11:6]), .PUMP_OFFSET_12P5UA(got[5:0]));
	function automatic logic [45:0] ex();
		return {m[0], (m[0][7] ? 7'h01 : m[0][6:0]), m[1][7:4], (m[1][5:4] == 2'h3 && !m[1][3]),
			m[1][3], m[2][7], !m[2][7], m[2][5:0], (m[2][4] ? 5'h10 + {1'h0, m[2][2:0], 1'h0} :
			{1'h0, m[2][3:0]}), m[3][5:0], {1'h0, m[3][5:4], 3'h0} + {2'h0, m[3][3:0]}};
	endfunction
	task chk(input logic [63:0] g, input logic [63:0] e);
		compares++;
		if (g !== e) failures++;
		if (g !== e) $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
	endtask
	task op(input logic w, input int i, input logic [7:0] d);
		@(negedge MCLK);
		{REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, ad[i], d};
		@(negedge MCLK);
		{REG_WR, REG_RD} = 2'h0;
		if (w && i < 4) m[i] = d & mk[i];
		if (!w) chk(got[53:46], (i < 4) ? m[i] : 8'h00);
	endtask
	task all();
		for (int i = 0; i < 5; i++) op(1'h0, i, 8'h00);
		chk(got[45:0], ex());
	endtask
	task rst();
		RESET_N = 1'h0;
		repeat (5) @(negedge MCLK);
		RESET_N = 1'h1;
		m = rs;
		all();
	endtask
	task results();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial forever #2 MCLK = !MCLK;
	initial begin
		rst();
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 5; i++) op(1'h1, i, cv[k]);
			all();
		end
		repeat (40) begin
			op(1'h1, $unsigned($random(seed)) % 5, 8'($random(seed)));
			all();
		end
		rst();
		results();
	end
endmodule // spllc_regs_test
`default_nettype wire
